/* logic/adf_format_ctrl.sv */
// Format register, serial control port, audio receiver, routing and modulator
`timescale 1ns/100ps
// Overview of operation
// - Format bit low: right-justified input; high: I2S input.
// - Polarity bit low: word select high is left; high reverses this.
// - Word length bit: 16 bits when low, 18 bits when high.
// - Shared attenuation bit high: left attenuation drives both channels.
// - Routing bits pick mute, right, left or half-sum per output.
// - After 1024 master clocks the settings return to defaults.
// - No control word is applied during the first 1024 master clocks.
// - Words may load during lockout; a falling latch afterwards applies them.
// - Conversion latency is 11.125 sample periods.
// - Eightfold interpolation; oversampling 48x at 384fs, 64x at 256fs.
// - Five-level quantizer with third-order noise shaping.
// - Control word bits 9 and 10 address; both one selects format register.
module adf_format_ctrl (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic bitClk,
  input wire logic word_select_input,
  input wire logic serialAudioIn,
  input wire logic control_shift_clock,
  input wire logic control_serial_data,
  input wire logic control_latch,
  input wire logic mclkIs384,
  input wire logic dacReady,
  input wire logic [7:0] leftAttenIn,
  input wire logic [7:0] rightAttenIn,
  output logic [17:0] leftOut,
  output logic [17:0] rightOut,
  output logic outStrobe,
  output logic [7:0] rightAttenEff,
  output logic [6:0] oversampleRatio,
  output logic [2:0] modLevelLeft,
  output logic [2:0] modLevelRight,
  output logic lockoutActive
);
  localparam int SB = adf_pkg::SAMPLE_BITS;
  localparam int MB = adf_pkg::MOD_BITS;
  typedef logic signed [MB-1:0] adf_mod_t;

  // Half-sum or selection of one output source
  function automatic logic [SB-1:0] adfRoute(input logic [1:0] code,
      input logic [SB-1:0] l, input logic [SB-1:0] r);
    logic [SB:0] sum;
    sum = {l[SB-1], l} + {r[SB-1], r};
    unique case (adf_pkg::adf_src_t'(code))
      adf_pkg::ADF_SRC_MUTE: adfRoute = '0;
      adf_pkg::ADF_SRC_RIGHT: adfRoute = r;
      adf_pkg::ADF_SRC_LEFT: adfRoute = l;
      adf_pkg::ADF_SRC_HALFSUM: adfRoute = sum[SB:1];
    endcase
  endfunction

  // Five-level quantizer: level index 0..4 from the shaped value
  function automatic logic [2:0] adfQuant(input adf_mod_t v);
    adf_mod_t t;
    t = v >>> 17;
    if (t > 1) adfQuant = 3'h4;
    else if (t < -2) adfQuant = 3'h0;
    else adfQuant = 3'(t + 2);
  endfunction

  // ---------------- Core domain: control port ----------------
  logic [2:0] sclkSync_reg;
  logic [2:0] sdatSync_reg;
  logic [2:0] latchSync_reg;
  logic sclkState_reg;
  logic latchState_reg;
  logic [15:0] ctrlShift_reg;
  logic [10:0] lockCnt_reg;
  logic [7:0] fmt_reg;
  logic [7:0] fmt_next;

  // Pin changes count once the second and third stages agree
  wire sclkAgree = (sclkSync_reg[1] == sclkSync_reg[2]);
  wire latchAgree = (latchSync_reg[1] == latchSync_reg[2]);
  wire sclkRise = sclkAgree && sclkSync_reg[2] && !sclkState_reg;
  wire latchFall = latchAgree && !latchSync_reg[2] && latchState_reg;
  wire lockDone = (lockCnt_reg == 11'(adf_pkg::LOCKOUT_CYCLES));
  wire lockEnd = (lockCnt_reg == 11'(adf_pkg::LOCKOUT_CYCLES - 1));
  wire [1:0] ctrlAddr = {ctrlShift_reg[adf_pkg::ADDR_HI_POS],
    ctrlShift_reg[adf_pkg::ADDR_LO_POS]};
  wire applyWord = latchFall && lockDone && (ctrlAddr == adf_pkg::FMT_REG_ADDR);

  // Next format value: defaults at lockout end, else the latched word
  always_comb begin
    fmt_next = fmt_reg;
    if (lockEnd) fmt_next = adf_pkg::FMT_RESET;
    else if (applyWord) fmt_next = ctrlShift_reg[7:0];
  end

  // Synchronisers and settled pin levels
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclkSync_reg <= 3'h0;
      sdatSync_reg <= 3'h0;
      latchSync_reg <= 3'h7;
      sclkState_reg <= 1'b0;
      latchState_reg <= 1'b1;
    end else begin
      sclkSync_reg <= {sclkSync_reg[1:0], control_shift_clock};
      sdatSync_reg <= {sdatSync_reg[1:0], control_serial_data};
      latchSync_reg <= {latchSync_reg[1:0], control_latch};
      if (sclkAgree) sclkState_reg <= sclkSync_reg[2];
      if (latchAgree) latchState_reg <= latchSync_reg[2];
    end
  end

  // Shift register, lockout counter and format register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlShift_reg <= 16'h0000;
      lockCnt_reg <= 11'h000;
      fmt_reg <= adf_pkg::FMT_RESET;
      lockoutActive <= 1'b1;
    end else begin
      if (sclkRise) ctrlShift_reg <= {ctrlShift_reg[14:0], sdatSync_reg[2]};
      if (!lockDone) lockCnt_reg <= lockCnt_reg + 11'h001;
      lockoutActive <= !lockDone && !lockEnd;
      fmt_reg <= fmt_next;
    end
  end

  wire sharedAtt = fmt_reg[adf_pkg::SHARED_ATT_POS];
  wire [1:0] routeL = {fmt_reg[adf_pkg::ROUTE_LSB_POS], fmt_reg[adf_pkg::ROUTE_LSB_POS+1]};
  wire [1:0] routeR = {fmt_reg[adf_pkg::ROUTE_LSB_POS+2], fmt_reg[adf_pkg::ROUTE_LSB_POS+3]};

  // ---------------- Link domain: serial audio receiver ----------------
  logic [2:0] cfgS1_reg;
  logic [2:0] cfgS2_reg;
  logic [2:0] cfgS3_reg;
  logic [SB-1:0] rxShift_reg;
  logic wsPrev_reg;
  logic [4:0] bitCnt_reg;
  logic [SB:0] pend_reg;
  logic pendValid_reg;
  adf_fifo_if #(.WIDTH(SB + 1)) fifoBus ();

  wire cfgI2s = cfgS3_reg[0];
  wire cfgPol = cfgS3_reg[1];
  wire cfgLong = cfgS3_reg[2];
  wire [4:0] wordLen = cfgLong ? 5'(SB) : 5'(adf_pkg::SHORT_BITS);
  wire wsEdge = (word_select_input != wsPrev_reg);
  wire prevIsLeft = wsPrev_reg ^ cfgPol;
  wire curIsLeft = word_select_input ^ cfgPol;
  wire [SB-1:0] rjSample = cfgLong ? rxShift_reg : {rxShift_reg[15:0], 2'b00};
  wire [SB-1:0] i2sNow = {rxShift_reg[SB-2:0], serialAudioIn};
  wire [SB-1:0] i2sSample = cfgLong ? i2sNow : {i2sNow[15:0], 2'b00};
  wire rjCapture = !cfgI2s && wsEdge;
  wire i2sCapture = cfgI2s && !wsEdge && (bitCnt_reg == wordLen - 5'h01);
  assign fifoBus.wrValid = pendValid_reg;
  assign fifoBus.wrData = pend_reg;

  // Settings crossing in: quasi-static levels, three flip-flops each
  always_ff @(posedge bitClk or negedge rst_n) begin
    if (!rst_n) begin
      cfgS1_reg <= 3'h0;
      cfgS2_reg <= 3'h0;
      cfgS3_reg <= 3'h0;
    end else begin
      cfgS1_reg <= fmt_reg[2:0];
      cfgS2_reg <= cfgS1_reg;
      cfgS3_reg <= cfgS2_reg;
    end
  end

  // Shift in audio bits, count bits since the last word-select edge
  always_ff @(posedge bitClk or negedge rst_n) begin
    if (!rst_n) begin
      rxShift_reg <= '0;
      wsPrev_reg <= 1'b0;
      bitCnt_reg <= 5'h00;
    end else begin
      rxShift_reg <= {rxShift_reg[SB-2:0], serialAudioIn};
      wsPrev_reg <= word_select_input;
      if (wsEdge) bitCnt_reg <= 5'h00;
      else if (bitCnt_reg != 5'h1F) bitCnt_reg <= bitCnt_reg + 5'h01;
    end
  end

  // Captured word waits here until the FIFO takes it
  always_ff @(posedge bitClk or negedge rst_n) begin
    if (!rst_n) begin
      pend_reg <= '0;
      pendValid_reg <= 1'b0;
    end else if (rjCapture) begin
      pend_reg <= {prevIsLeft, rjSample};
      pendValid_reg <= 1'b1;
    end else if (i2sCapture) begin
      pend_reg <= {curIsLeft, i2sSample};
      pendValid_reg <= 1'b1;
    end else if (fifoBus.wrReady) begin
      pendValid_reg <= 1'b0;
    end
  end

  adf_sample_fifo #(.WIDTH(SB + 1), .DEPTH(8)) u_fifo (
    .wrClk(bitClk),
    .rdClk(core_clk),
    .rst_n(rst_n),
    .port(fifoBus.fifo)
  );

  // ---------------- Core domain: pairing, latency, routing ----------------
  logic [SB-1:0] leftHold_reg;
  logic [2*SB-1:0] delayLine [adf_pkg::LATENCY_SAMPLES + 1];
  logic pairDone_reg;
  logic [2:0] interpPhase_reg;

  assign fifoBus.rdReady = dacReady;
  wire popWord = fifoBus.rdValid && dacReady;
  wire popLeft = popWord && fifoBus.rdData[SB];
  wire popRight = popWord && !fifoBus.rdData[SB];
  wire [SB-1:0] dlyL = delayLine[adf_pkg::LATENCY_SAMPLES][2*SB-1:SB];
  wire [SB-1:0] dlyR = delayLine[adf_pkg::LATENCY_SAMPLES][SB-1:0];

  // Sample pairs run through an eleven-period delay line
  always_ff @(posedge core_clk) begin
    if (popRight) begin
      delayLine[0] <= {leftHold_reg, fifoBus.rdData[SB-1:0]};
      for (int i = 1; i <= adf_pkg::LATENCY_SAMPLES; i++) begin
        delayLine[i] <= delayLine[i-1];
      end
    end
  end

  // Output pair, attenuation selection, oversampling ratio
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      leftHold_reg <= '0;
      pairDone_reg <= 1'b0;
      leftOut <= '0;
      rightOut <= '0;
      outStrobe <= 1'b0;
      rightAttenEff <= 8'h00;
      oversampleRatio <= adf_pkg::OSR_256;
      interpPhase_reg <= 3'h0;
    end else begin
      if (popLeft) leftHold_reg <= fifoBus.rdData[SB-1:0];
      pairDone_reg <= popRight;
      outStrobe <= pairDone_reg;
      if (pairDone_reg) begin
        leftOut <= adfRoute(routeL, dlyL, dlyR);
        rightOut <= adfRoute(routeR, dlyL, dlyR);
      end
      rightAttenEff <= sharedAtt ? leftAttenIn : rightAttenIn;
      oversampleRatio <= mclkIs384 ? adf_pkg::OSR_384 : adf_pkg::OSR_256;
      interpPhase_reg <= pairDone_reg ? 3'h0 : 3'(interpPhase_reg + 3'h1);
    end
  end

  // ---------------- Third-order error-feedback modulator ----------------
  adf_mod_t e1 [2];
  adf_mod_t e2 [2];
  adf_mod_t e3 [2];
  adf_mod_t shaped [2];
  adf_mod_t quantVal [2];
  logic [2:0] level [2];
  wire [SB-1:0] modIn [2];
  assign modIn[0] = leftOut;
  assign modIn[1] = rightOut;

  for (genvar c = 0; c < 2; c++) begin : g_mod
    // Shaped value and its five-level quantization
    assign shaped[c] = adf_mod_t'(adf_mod_t'($signed(modIn[c]))
      - (3 * e1[c] - 3 * e2[c] + e3[c]));
    assign level[c] = adfQuant(shaped[c]);
    assign quantVal[c] = adf_mod_t'($signed({1'b0, level[c]}) - 4'sd2) <<< 17;
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        e1[c] <= '0;
        e2[c] <= '0;
        e3[c] <= '0;
      end else begin
        e1[c] <= quantVal[c] - shaped[c];
        e2[c] <= e1[c];
        e3[c] <= e2[c];
      end
    end
  end

  // Modulator level outputs
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      modLevelLeft <= 3'h2;
      modLevelRight <= 3'h2;
    end else begin
      modLevelLeft <= level[0];
      modLevelRight <= level[1];
    end
  end

  // ---------------- Assertions ----------------
  sequence s_latchApply;
    applyWord ##1 1'b1;
  endsequence
  property p_lockout_hold;
    @(posedge core_clk) disable iff (!rst_n) !lockDone && !lockEnd |=> $stable(fmt_reg);
  endproperty
  a_lockout_hold: assert property (p_lockout_hold) else $error("format changed in lockout");
  property p_defaults;
    @(posedge core_clk) disable iff (!rst_n) lockEnd |=> fmt_reg == adf_pkg::FMT_RESET;
  endproperty
  a_defaults: assert property (p_defaults) else $error("defaults not restored");
  property p_apply;
    @(posedge core_clk) disable iff (!rst_n)
      s_latchApply |-> fmt_reg == $past(ctrlShift_reg[7:0]);
  endproperty
  a_apply: assert property (p_apply) else $error("latched word not applied");
  property p_addr;
    @(posedge core_clk) disable iff (!rst_n)
      latchFall && ctrlAddr != adf_pkg::FMT_REG_ADDR && !lockEnd |=> $stable(fmt_reg);
  endproperty
  a_addr: assert property (p_addr) else $error("other address changed format");
  property p_mute;
    @(posedge core_clk) disable iff (!rst_n)
      pairDone_reg && routeL == 2'b00 |=> leftOut == '0 && outStrobe;
  endproperty
  a_mute: assert property (p_mute) else $error("muted output not zero");
  property p_shared;
    @(posedge core_clk) disable iff (!rst_n) sharedAtt |=> rightAttenEff == $past(leftAttenIn);
  endproperty
  a_shared: assert property (p_shared) else $error("shared attenuation wrong");
  property p_osr;
    @(posedge core_clk) disable iff (!rst_n)
      mclkIs384 [*2] |-> ##1 oversampleRatio == adf_pkg::OSR_384;
  endproperty
  a_osr: assert property (p_osr) else $error("oversampling ratio wrong");
  property p_level;
    @(posedge core_clk) disable iff (!rst_n) modLevelLeft <= 3'h4 && modLevelRight <= 3'h4;
  endproperty
  a_level: assert property (p_level) else $error("modulator level out of range");
  property p_short_word;
    @(posedge bitClk) disable iff (!rst_n) rjCapture && !cfgLong |=> pend_reg[1:0] == 2'b00;
  endproperty
  a_short_word: assert property (p_short_word) else $error("16-bit word not aligned");
endmodule // adf_format_ctrl

/* logic/adf_pkg.sv */
// Shared constants and types of the audio format and output control block
package adf_pkg;
  // Control word layout
  localparam int CTRL_WORD_BITS = 16;
  localparam int ADDR_LO_POS = 9;
  localparam int ADDR_HI_POS = 10;
  localparam logic [1:0] FMT_REG_ADDR = 2'h3;
  // Format register fields
  localparam int FMT_SEL_POS = 0;
  localparam int WS_POL_POS = 1;
  localparam int WLEN_POS = 2;
  localparam int SHARED_ATT_POS = 3;
  localparam int ROUTE_LSB_POS = 4;
  localparam logic [7:0] FMT_RESET = 8'h00;
  // Power-on lockout, in master clock cycles
  localparam int LOCKOUT_CYCLES = 1024;
  // Audio word
  localparam int SAMPLE_BITS = 18;
  localparam int SHORT_BITS = 16;
  // Latency in eighths of a sample period, whole periods held in the delay line
  localparam int LATENCY_EIGHTHS = 89;
  localparam int LATENCY_SAMPLES = LATENCY_EIGHTHS / 8;
  // Oversampling
  localparam int INTERP_FACTOR = 8;
  localparam logic [6:0] OSR_384 = 7'h30;
  localparam logic [6:0] OSR_256 = 7'h40;
  // Modulator
  localparam int MOD_LEVELS = 5;
  localparam int MOD_ORDER = 3;
  localparam int MOD_BITS = 22;
  // Routing source codes, written {first bit, second bit}
  typedef enum logic [1:0] {
    ADF_SRC_MUTE = 2'b00,
    ADF_SRC_RIGHT = 2'b01,
    ADF_SRC_LEFT = 2'b10,
    ADF_SRC_HALFSUM = 2'b11
  } adf_src_t;
endpackage

/* logic/adf_fifo_if.sv */
// Carrier between the link-side writer and the core-side reader of the sample FIFO
`timescale 1ns/100ps
interface adf_fifo_if #(parameter int WIDTH = 19);
  logic wrValid;
  logic wrReady;
  logic [WIDTH-1:0] wrData;
  logic rdValid;
  logic rdReady;
  logic [WIDTH-1:0] rdData;
  modport writer (output wrValid, output wrData, input wrReady);
  modport reader (input rdValid, input rdData, output rdReady);
  modport fifo (input wrValid, input wrData, output wrReady,
    output rdValid, output rdData, input rdReady);
endinterface

/* logic/adf_sample_fifo.sv */
// Dual-clock sample FIFO with gray-coded pointers
`timescale 1ns/100ps
module adf_sample_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 8
) (
  input wire logic wrClk,
  input wire logic rdClk,
  input wire logic rst_n,
  adf_fifo_if.fifo port
);
  localparam int AW = $clog2(DEPTH);

  // Gray pointers need a power-of-two depth
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("DEPTH must be a power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wBin_reg;
  logic [AW:0] wGray_reg;
  logic [AW:0] rBin_reg;
  logic [AW:0] rGray_reg;
  logic [AW:0] rGrayW1_reg;
  logic [AW:0] rGrayW2_reg;
  logic [AW:0] rGrayW3_reg;
  logic [AW:0] wGrayR1_reg;
  logic [AW:0] wGrayR2_reg;
  logic [AW:0] wGrayR3_reg;
  wire [AW:0] wBinNext = wBin_reg + 1'b1;
  wire [AW:0] rBinNext = rBin_reg + 1'b1;
  wire full = (wGray_reg == {~rGrayW3_reg[AW:AW-1], rGrayW3_reg[AW-2:0]});
  wire empty = (rGray_reg == wGrayR3_reg);
  wire doWrite = port.wrValid && !full;
  wire doRead = port.rdReady && !empty;

  assign port.wrReady = !full;
  assign port.rdValid = !empty;
  assign port.rdData = mem[rBin_reg[AW-1:0]];

  // Write side, link clock
  always_ff @(posedge wrClk or negedge rst_n) begin
    if (!rst_n) begin
      wBin_reg <= '0;
      wGray_reg <= '0;
      rGrayW1_reg <= '0;
      rGrayW2_reg <= '0;
      rGrayW3_reg <= '0;
    end else begin
      rGrayW1_reg <= rGray_reg;
      rGrayW2_reg <= rGrayW1_reg;
      rGrayW3_reg <= rGrayW2_reg;
      if (doWrite) begin
        wBin_reg <= wBinNext;
        wGray_reg <= wBinNext ^ (wBinNext >> 1);
      end
    end
  end

  // Storage, written on the link clock only
  always_ff @(posedge wrClk) begin
    if (doWrite) mem[wBin_reg[AW-1:0]] <= port.wrData;
  end

  // Read side, core clock
  always_ff @(posedge rdClk or negedge rst_n) begin
    if (!rst_n) begin
      rBin_reg <= '0;
      rGray_reg <= '0;
      wGrayR1_reg <= '0;
      wGrayR2_reg <= '0;
      wGrayR3_reg <= '0;
    end else begin
      wGrayR1_reg <= wGray_reg;
      wGrayR2_reg <= wGrayR1_reg;
      wGrayR3_reg <= wGrayR2_reg;
      if (doRead) begin
        rBin_reg <= rBinNext;
        rGray_reg <= rBinNext ^ (rBinNext >> 1);
      end
    end
  end

  property p_full_refuses;
    @(posedge wrClk) disable iff (!rst_n) full |=> wBin_reg == $past(wBin_reg);
  endproperty
  a_full_refuses: assert property (p_full_refuses) else $error("write taken while full");
endmodule // adf_sample_fifo

/* dv/adf_audio_partner.sv */
// Audio source and control-port controller facing the format block
`timescale 1ns/100ps
module adf_audio_partner (
  input wire logic core_clk,
  input wire logic [2:0] fmtBits,
  input wire logic countMode,
  input wire logic [17:0] lVal,
  input wire logic [17:0] rVal,
  output logic bitClk,
  output logic wsOut,
  output logic dataOut,
  output logic shiftClk,
  output logic shiftData,
  output logic latchOut
);
  logic [7:0] frameNo = 8'h00;

  // Free-running bit clock while frames flow, offset from the core clock
  initial begin
    bitClk = 1'b0;
    wsOut = 1'b0;
    dataOut = 1'b0;
    shiftClk = 1'b0;
    shiftData = 1'b0;
    latchOut = 1'b1;
    #3.1;
    forever #7.5 bitClk = ~bitClk;
  end

  // One channel half of 24 bit clocks, data changed on the falling edge
  task automatic sendHalf(input logic left, input logic [17:0] val);
    int nBits;
    int start;
    nBits = fmtBits[2] ? 18 : 16;
    start = fmtBits[0] ? 1 : 24 - nBits;
    for (int i = 0; i < 24; i++) begin
      @(negedge bitClk);
      if (i == 0) wsOut = left ^ fmtBits[1];
      if (i >= start && i < start + nBits) dataOut = val[17 - (i - start)];
      else dataOut = ~dataOut; // Filler bits toggle
    end
  endtask

  // Frames: left half first, then right half
  always begin
    frameNo = frameNo + 8'h01;
    sendHalf(1'b1, countMode ? {10'h000, frameNo} : lVal);
    sendHalf(1'b0, rVal);
  end

  // Pin step aligned just after a core edge
  task automatic ctrlStep();
    repeat (6) @(posedge core_clk);
    #1;
  endtask

  // Shift one control word, MSB first, reserved bits zero
  task automatic shiftWord(input logic [1:0] addr, input logic [7:0] val);
    logic [15:0] w;
    w = {5'h00, addr, 1'b0, val};
    for (int i = 15; i >= 0; i--) begin
      ctrlStep();
      shiftData = w[i];
      ctrlStep();
      shiftClk = 1'b1;
      ctrlStep();
      shiftClk = 1'b0;
    end
    ctrlStep();
    shiftData = ~shiftData; // Data line inverted after the last bit
  endtask

  // Latch low then back to idle high
  task automatic latchPulse();
    ctrlStep();
    latchOut = 1'b0;
    ctrlStep();
    latchOut = 1'b1;
    ctrlStep();
  endtask
endmodule // adf_audio_partner

/* dv/adf_format_ctrl_test.sv */
// Self-checking bench of the format and output control block
`timescale 1ns/100ps
module adf_format_ctrl_test;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic mclkIs384 = 1'b0;
  logic dacReady = 1'b1;
  logic [7:0] leftAttenIn = 8'hA5;
  logic [7:0] rightAttenIn = 8'h3C;
  logic [2:0] fmtBits = 3'h0;
  logic countMode = 1'b0;
  logic [17:0] lVal = 18'h1A2B4;
  logic [17:0] rVal = 18'h2C0F8;
  logic bitClk, wsIn, sdIn, shClk, shData, latch;
  logic [17:0] leftOut, rightOut;
  logic outStrobe, lockoutActive;
  logic [7:0] rightAttenEff;
  logic [6:0] oversampleRatio;
  logic [2:0] modLevelLeft, modLevelRight;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;
  int seen;
  logic [7:0] e;

  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;

  adf_format_ctrl dut (.core_clk(core_clk), .rst_n(rst_n), .bitClk(bitClk),
    .word_select_input(wsIn), .serialAudioIn(sdIn), .control_shift_clock(shClk),
    .control_serial_data(shData), .control_latch(latch), .mclkIs384(mclkIs384),
    .dacReady(dacReady), .leftAttenIn(leftAttenIn), .rightAttenIn(rightAttenIn),
    .leftOut(leftOut), .rightOut(rightOut), .outStrobe(outStrobe),
    .rightAttenEff(rightAttenEff), .oversampleRatio(oversampleRatio),
    .modLevelLeft(modLevelLeft), .modLevelRight(modLevelRight),
    .lockoutActive(lockoutActive));

  adf_audio_partner partner (.core_clk(core_clk), .fmtBits(fmtBits), .countMode(countMode),
    .lVal(lVal), .rVal(rVal), .bitClk(bitClk), .wsOut(wsIn), .dataOut(sdIn),
    .shiftClk(shClk), .shiftData(shData), .latchOut(latch));

  // Compare one value and count it
  task automatic check(input string name, input logic [17:0] exp, input logic [17:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Verdict and end of run
  task automatic stop_test();
    if (failures == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Step n core cycles, settled after the last edge
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // Wait for n output strobes, each under a bound
  task automatic waitStrobes(input int n);
    int t;
    for (int k = 0; k < n; k++) begin
      t = 0;
      while (outStrobe !== 1'b1) begin
        tick(1);
        t++;
        if (t > 400) begin
          failures++;
          stop_test();
        end
      end
      check("modLevelLeft", 18'h1, {17'h0, modLevelLeft <= 3'h4});
      check("modLevelRight", 18'h1, {17'h0, modLevelRight <= 3'h4});
      tick(1);
    end
  endtask

  // Expected routed source
  function automatic logic [17:0] pick(input logic [1:0] c, input logic [17:0] l,
      input logic [17:0] r);
    logic [18:0] s;
    s = {l[17], l} + {r[17], r};
    case (c)
      2'b00: pick = 18'h00000;
      2'b01: pick = r;
      2'b10: pick = l;
      default: pick = s[18:1];
    endcase
  endfunction

  // Write a format word, let the stream settle, compare outputs
  task automatic runCfg(input logic [7:0] b);
    logic [17:0] l;
    logic [17:0] r;
    fmtBits = b[2:0];
    partner.shiftWord(2'h3, b);
    partner.latchPulse();
    l = b[2] ? lVal : {lVal[17:2], 2'b00};
    r = b[2] ? rVal : {rVal[17:2], 2'b00};
    waitStrobes(15);
    check("leftOut", pick({b[4], b[5]}, l, r), leftOut);
    check("rightOut", pick({b[6], b[7]}, l, r), rightOut);
    check("rightAttenEff", {10'h0, b[3] ? leftAttenIn : rightAttenIn}, {10'h0, rightAttenEff});
  endtask

  // Main sequence
  initial begin
    tick(2);
    check("lockoutActive", 18'h1, {17'h0, lockoutActive});
    check("oversampleRatio", 18'h40, {11'h0, oversampleRatio});
    check("modLevelLeft", 18'h2, {15'h0, modLevelLeft});
    tick(2);
    rst_n = 1'b1;
    partner.shiftWord(2'h3, 8'h08);
    partner.latchPulse();
    tick(8);
    check("rightAttenEff", {10'h0, rightAttenIn}, {10'h0, rightAttenEff});
    check("lockoutActive", 18'h1, {17'h0, lockoutActive});
    while (cyc < 1020) tick(1);
    check("lockoutActive", 18'h1, {17'h0, lockoutActive});
    tick(8);
    check("lockoutActive", 18'h0, {17'h0, lockoutActive});
    check("leftOut", 18'h0, leftOut);
    check("rightAttenEff", {10'h0, rightAttenIn}, {10'h0, rightAttenEff});
    partner.latchPulse();
    check("rightAttenEff", {10'h0, leftAttenIn}, {10'h0, rightAttenEff});
    for (int a = 0; a < 3; a++) begin
      partner.shiftWord(2'(a), 8'h00);
      partner.latchPulse();
      check("rightAttenEff", {10'h0, leftAttenIn}, {10'h0, rightAttenEff});
    end
    for (int f = 0; f < 8; f++) runCfg({5'h12, 3'(f)});
    for (int r = 0; r < 16; r++) begin
      mclkIs384 = r[1];
      runCfg({4'(r), r[0], 3'b100});
      check("oversampleRatio", {11'h0, r[1] ? 7'h30 : 7'h40}, {11'h0, oversampleRatio});
    end
    runCfg(8'h94);
    countMode = 1'b1;
    waitStrobes(15);
    for (int k = 0; k < 3; k++) begin
      waitStrobes(1);
      e = partner.frameNo - 8'h0C;
      check("leftOut", {10'h0, e}, leftOut);
    end
    countMode = 1'b0;
    dacReady = 1'b0;
    tick(20);
    seen = 0;
    for (int k = 0; k < 520; k++) begin
      tick(1);
      if (outStrobe !== 1'b0) seen++;
    end
    check("outStrobe", 18'h0, 18'(seen));
    dacReady = 1'b1;
    waitStrobes(15);
    check("leftOut", lVal, leftOut);
    check("rightOut", rVal, rightOut);
    stop_test();
  end
endmodule // adf_format_ctrl_test
